// >>> hdl/fiar_axil.sv
// Purpose: AXI4-Lite slave front end
// Assumes: one write and one read outstanding at most
// Notes: unmapped or misaligned address answers SLVERR
`timescale 1ns/1ps
`include "fiar_defs.svh"
module fiar_axil (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [`FIAR_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`FIAR_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   fiar_reg_if.bus rif
);
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [`FIAR_AW-1:0] addr_q, addr_d;
   logic [31:0] data_q, data_d;
   logic [3:0] strb_q, strb_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic do_wr;

   function automatic logic addr_ok(input logic [`FIAR_AW-1:0] a);
      return (a <= `FIAR_ADDR_LAST) && (a[1:0] == 2'h0);
   endfunction

   assign awready = ce & ~aw_have_q & ~bvalid_q;
   assign wready = ce & ~w_have_q & ~bvalid_q;
   assign arready = ce & ~rvalid_q;

   // ==========================================================
   // Write channel
   always_comb begin
      aw_have_d = aw_have_q | (awvalid & awready);
      addr_d = (awvalid & awready) ? awaddr : addr_q;
      w_have_d = w_have_q | (wvalid & wready);
      data_d = (wvalid & wready) ? wdata : data_q;
      strb_d = (wvalid & wready) ? wstrb : strb_q;
      bvalid_d = bvalid_q & ~bready;
      bresp_d = bresp_q;
      do_wr = aw_have_d & w_have_d & ~bvalid_q;
      if (do_wr) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = addr_ok(addr_d) ? `FIAR_RESP_OK : `FIAR_RESP_ERR;
      end
   end
   assign rif.wr_en = ce & do_wr & addr_ok(addr_d);
   assign rif.wr_addr = addr_d;
   assign rif.wr_data = data_d;
   assign rif.wr_strb = strb_d;

   // ==========================================================
   // Read channel
   assign rif.rd_addr = araddr;
   always_comb begin
      rvalid_d = rvalid_q & ~rready;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (arvalid & arready) begin
         rvalid_d = 1'b1;
         rdata_d = addr_ok(araddr) ? rif.rd_data : 32'h0;
         rresp_d = addr_ok(araddr) ? `FIAR_RESP_OK : `FIAR_RESP_ERR;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         addr_q <= 8'h00;
         data_q <= 32'h0;
         strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= 2'h0;
      end else if (ce) begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         addr_q <= addr_d;
         data_q <= data_d;
         strb_q <= strb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
endmodule

// >>> hdl/fiar_defs.svh
// Function
// - Servo axis driven toward switch at feedrate.
// - Position latched at index/null, dimension loaded.
// - Out-of-range dimension refused, no success output.
// - Option bits: ignore index, no motion, null setup.
// - Digitizing or no-motion: no motion generated.
// - Trigger edge selectable, rising by default.
// - Encoder axis keeps moving until next index.
// - No-motion watches only, yet needs free queue.
// - Done flag cleared by command, set at reference.
// - No-motion reference leaves running moves untouched.
// - Null setup stores null position in drive.
// - Switch position readable: offset or resolver angle.
// - Switch edge captured in hardware, not scan.
// - Queue number of reference move reported.
// - Stepper axis commands rejected.
// Purpose: offsets, fields, reset values of the reference block
// Assumes: 32-bit AXI4-Lite, byte addresses
// Notes: definitions only
`ifndef FIAR_DEFS_SVH
`define FIAR_DEFS_SVH
// ==========================================================
// Register offsets
`define FIAR_AW 8
`define FIAR_REG_CTRL 8'h00
`define FIAR_REG_AXIS 8'h04
`define FIAR_REG_RATE 8'h08
`define FIAR_REG_DIM 8'h0C
`define FIAR_REG_OPT 8'h10
`define FIAR_REG_CFG 8'h14
`define FIAR_REG_STAT 8'h18
`define FIAR_REG_POS 8'h1C
`define FIAR_REG_SWPOS 8'h20
`define FIAR_ADDR_LAST 8'h20
// ==========================================================
// Fields
`define FIAR_CTRL_START 0
`define FIAR_CTRL_PLUS 1
`define FIAR_OPT_IGNIDX 0
`define FIAR_OPT_NOMOVE 1
`define FIAR_OPT_NULLSET 2
`define FIAR_CFG_FALL 0
`define FIAR_CFG_KIND_LO 1
`define FIAR_CFG_RESOLVER 3
`define FIAR_CFG_DDRIVE 4
`define FIAR_CFG_W 5
`define FIAR_CFG_RESET 5'h00
`define FIAR_DIM_TOP 29
`define FIAR_RESP_OK 2'h0
`define FIAR_RESP_ERR 2'h2
`endif

// >>> hdl/fiar_edge.sv
// Purpose: two-flop synchroniser with selectable edge pulse
// Assumes: pin_raw asynchronous to sys_clk
// Notes: pulse comes from second and third flops only
`timescale 1ns/1ps
`include "fiar_defs.svh"
module fiar_edge (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic pin_raw,
   input wire logic fall_sel,
   output logic edge_pulse
);
   logic [2:0] sh_q;
   logic [2:0] sh_d;
   always_comb begin
      sh_d = {sh_q[1:0], pin_raw};
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sh_q <= 3'h0;
      end else if (ce) begin
         sh_q <= sh_d;
      end
   end
   // Single-cycle detect of chosen edge
   assign edge_pulse = ce & (fall_sel ? (sh_q[2] & ~sh_q[1]) : (~sh_q[2] & sh_q[1]));
endmodule

// >>> hdl/fiar_pkg.sv
// Purpose: shared types of the reference block
// Assumes: nothing
// Notes: constants live in fiar_defs.svh
package fiar_pkg;
   typedef enum {ST_IDLE, ST_SEEK, ST_HUNT} fiar_state_t;
   typedef enum logic [1:0] {KIND_SERVO, KIND_DIGITIZE, KIND_STEPPER} fiar_kind_t;
   function automatic logic [31:0] fiar_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

// >>> hdl/fiar_reg_if.sv
// Purpose: register access path between bus slave and core
// Assumes: one clock
// Notes: write is a one-cycle strobe, read is combinational
`timescale 1ns/1ps
`include "fiar_defs.svh"
interface fiar_reg_if;
   logic wr_en;
   logic [`FIAR_AW-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [`FIAR_AW-1:0] rd_addr;
   logic [31:0] rd_data;
   modport bus (output wr_en, output wr_addr, output wr_data, output wr_strb,
      output rd_addr, input rd_data);
   modport core (input wr_en, input wr_addr, input wr_data, input wr_strb,
      input rd_addr, output rd_data);
endinterface

// >>> hdl/fiar_top.sv
// Purpose: fast-input machine reference for one axis
// Assumes: feedback_pos and queue_free on sys_clk; pins asynchronous
// Notes: resolver null arrives as a pulse on index_in
`timescale 1ns/1ps
`include "fiar_defs.svh"
module fiar_top (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [`FIAR_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`FIAR_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic fast_in,
   input wire logic index_in,
   input wire logic [31:0] feedback_pos,
   input wire logic queue_free,
   output logic move_en,
   output logic move_plus,
   output logic [31:0] move_rate,
   output logic [7:0] axis_id,
   output logic [7:0] queue_number,
   output logic ref_done,
   output logic [31:0] axis_position,
   output logic nv_store,
   output logic [31:0] nv_null_pos
);
   fiar_reg_if rif();
   logic fast_pulse, index_pulse;

   // ==========================================================
   // Command and configuration registers
   logic plus_q, plus_d;
   logic [7:0] axis_q, axis_d;
   logic [31:0] rate_q, rate_d, dim_q, dim_d;
   logic [15:0] opt_q, opt_d;
   logic [`FIAR_CFG_W-1:0] cfg_q, cfg_d;
   logic start;
   logic [31:0] ctrl_w;
   logic [31:0] axis_m, opt_m, cfg_m;

   // ==========================================================
   // Reference state
   fiar_pkg::fiar_state_t state_q, state_d;
   logic done_q, done_d, ok_q, ok_d, reject_q, reject_d, swvalid_q, swvalid_d;
   logic motion_q, motion_d, moving_q, moving_d, nv_q, nv_d;
   logic [7:0] queue_q, queue_d, qcnt_q, qcnt_d;
   logic [31:0] offset_q, offset_d, latch_q, latch_d, swpos_q, swpos_d;
   logic [31:0] nvpos_q, nvpos_d, pos_q, pos_d;
   logic dim_ok, accept, complete, motion_req;
   fiar_pkg::fiar_kind_t kind;

   fiar_axil u_axil (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ce(ce),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .rif(rif.bus)
   );

   // Switch edge captured in logic, not by software polling
   fiar_edge u_fast (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ce(ce),
      .pin_raw(fast_in),
      .fall_sel(cfg_q[`FIAR_CFG_FALL]),
      .edge_pulse(fast_pulse)
   );
   fiar_edge u_index (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ce(ce),
      .pin_raw(index_in),
      .fall_sel(1'b0),
      .edge_pulse(index_pulse)
   );

   // ==========================================================
   // Register writes
   always_comb begin
      plus_d = plus_q;
      axis_d = axis_q;
      rate_d = rate_q;
      dim_d = dim_q;
      opt_d = opt_q;
      cfg_d = cfg_q;
      start = 1'b0;
      ctrl_w = fiar_pkg::fiar_merge(32'h0, rif.wr_data, rif.wr_strb);
      axis_m = fiar_pkg::fiar_merge({24'h0, axis_q}, rif.wr_data, rif.wr_strb);
      opt_m = fiar_pkg::fiar_merge({16'h0, opt_q}, rif.wr_data, rif.wr_strb);
      cfg_m = fiar_pkg::fiar_merge({27'h0, cfg_q}, rif.wr_data, rif.wr_strb);
      if (rif.wr_en) begin
         case (rif.wr_addr)
            `FIAR_REG_CTRL: begin
               // Write of start bit is the one-cycle command
               start = ctrl_w[`FIAR_CTRL_START];
               if (rif.wr_strb[0]) begin
                  plus_d = ctrl_w[`FIAR_CTRL_PLUS];
               end
            end
            `FIAR_REG_AXIS: axis_d = axis_m[7:0];
            `FIAR_REG_RATE: rate_d = fiar_pkg::fiar_merge(rate_q, rif.wr_data, rif.wr_strb);
            `FIAR_REG_DIM: dim_d = fiar_pkg::fiar_merge(dim_q, rif.wr_data, rif.wr_strb);
            `FIAR_REG_OPT: opt_d = opt_m[15:0];
            // Edge select defaults to rising at reset
            `FIAR_REG_CFG: cfg_d = cfg_m[`FIAR_CFG_W-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Reference sequence
   assign kind = fiar_pkg::fiar_kind_t'(cfg_q[`FIAR_CFG_KIND_LO +: 2]);
   // Dimension must fit -2^29 .. 2^29-1
   assign dim_ok = (dim_q[31:`FIAR_DIM_TOP] == 3'h0) || (dim_q[31:`FIAR_DIM_TOP] == 3'h7);
   // Stepper refused; queue slot needed even without motion
   assign accept = start & dim_ok & queue_free & (kind != fiar_pkg::KIND_STEPPER);
   // Bit-flag decode of options
   assign motion_req = (kind == fiar_pkg::KIND_SERVO) & ~opt_q[`FIAR_OPT_NOMOVE];

   always_comb begin
      state_d = state_q;
      done_d = done_q;
      ok_d = ok_q;
      reject_d = reject_q;
      swvalid_d = swvalid_q;
      motion_d = motion_q;
      queue_d = queue_q;
      qcnt_d = qcnt_q;
      offset_d = offset_q;
      latch_d = latch_q;
      swpos_d = swpos_q;
      nvpos_d = nvpos_q;
      nv_d = 1'b0;
      complete = 1'b0;
      case (state_q)
         fiar_pkg::ST_SEEK: begin
            if (fast_pulse) begin
               latch_d = feedback_pos;
               if (opt_q[`FIAR_OPT_IGNIDX]) begin
                  // Load at the switch and stop now
                  offset_d = dim_q - feedback_pos;
                  swpos_d = feedback_pos;
                  swvalid_d = cfg_q[`FIAR_CFG_RESOLVER];
                  complete = 1'b1;
                  state_d = fiar_pkg::ST_IDLE;
               end else begin
                  // Encoder keeps moving to the next index
                  state_d = fiar_pkg::ST_HUNT;
               end
            end
         end
         fiar_pkg::ST_HUNT: begin
            if (index_pulse) begin
               // Position at mark takes the dimension
               offset_d = dim_q - feedback_pos;
               // Counts switch-to-index, or resolver angle at switch
               swpos_d = cfg_q[`FIAR_CFG_RESOLVER] ? latch_q : feedback_pos - latch_q;
               swvalid_d = 1'b1;
               complete = 1'b1;
               state_d = fiar_pkg::ST_IDLE;
               // Drive keeps this null in its own flash
               if (opt_q[`FIAR_OPT_NULLSET] && cfg_q[`FIAR_CFG_DDRIVE]) begin
                  nv_d = 1'b1;
                  nvpos_d = feedback_pos;
               end
            end
         end
         default: ;
      endcase
      if (start) begin
         if (accept) begin
            state_d = fiar_pkg::ST_SEEK;
            ok_d = 1'b1;
            reject_d = 1'b0;
            motion_d = motion_req;
            if (motion_req) begin
               // Number of the generated move
               qcnt_d = qcnt_q + 8'h01;
               queue_d = qcnt_q + 8'h01;
            end
         end else begin
            ok_d = 1'b0;
            reject_d = 1'b1;
         end
      end
      // A completion in the same cycle as a command keeps done set
      if (complete) begin
         done_d = 1'b1;
      end else if (accept) begin
         done_d = 1'b0;
      end
      // Only the own reference move is driven; other moves untouched
      moving_d = motion_d & (state_d != fiar_pkg::ST_IDLE);
      // Position follows feedback through the reference offset
      pos_d = feedback_pos + offset_q;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         plus_q <= 1'b0;
         axis_q <= 8'h00;
         rate_q <= 32'h0;
         dim_q <= 32'h0;
         opt_q <= 16'h0;
         cfg_q <= `FIAR_CFG_RESET;
         state_q <= fiar_pkg::ST_IDLE;
         done_q <= 1'b0;
         ok_q <= 1'b0;
         reject_q <= 1'b0;
         swvalid_q <= 1'b0;
         motion_q <= 1'b0;
         moving_q <= 1'b0;
         nv_q <= 1'b0;
         queue_q <= 8'h00;
         qcnt_q <= 8'h00;
         offset_q <= 32'h0;
         latch_q <= 32'h0;
         swpos_q <= 32'h0;
         nvpos_q <= 32'h0;
         pos_q <= 32'h0;
      end else if (ce) begin
         plus_q <= plus_d;
         axis_q <= axis_d;
         rate_q <= rate_d;
         dim_q <= dim_d;
         opt_q <= opt_d;
         cfg_q <= cfg_d;
         state_q <= state_d;
         done_q <= done_d;
         ok_q <= ok_d;
         reject_q <= reject_d;
         swvalid_q <= swvalid_d;
         motion_q <= motion_d;
         moving_q <= moving_d;
         nv_q <= nv_d;
         queue_q <= queue_d;
         qcnt_q <= qcnt_d;
         offset_q <= offset_d;
         latch_q <= latch_d;
         swpos_q <= swpos_d;
         nvpos_q <= nvpos_d;
         pos_q <= pos_d;
      end
   end

   // ==========================================================
   // Outputs and read mux
   assign move_en = moving_q;
   assign move_plus = plus_q;
   assign move_rate = rate_q;
   assign axis_id = axis_q;
   assign queue_number = queue_q;
   assign ref_done = done_q;
   assign axis_position = pos_q;
   assign nv_store = nv_q;
   assign nv_null_pos = nvpos_q;

   always_comb begin
      case (rif.rd_addr)
         `FIAR_REG_CTRL: rif.rd_data = {30'h0, plus_q, 1'b0};
         `FIAR_REG_AXIS: rif.rd_data = {24'h0, axis_q};
         `FIAR_REG_RATE: rif.rd_data = rate_q;
         `FIAR_REG_DIM: rif.rd_data = dim_q;
         `FIAR_REG_OPT: rif.rd_data = {16'h0, opt_q};
         `FIAR_REG_CFG: rif.rd_data = {27'h0, cfg_q};
         `FIAR_REG_STAT: rif.rd_data = {16'h0, queue_q, 3'h0, swvalid_q, reject_q,
            (state_q != fiar_pkg::ST_IDLE), ok_q, done_q};
         `FIAR_REG_POS: rif.rd_data = pos_q;
         `FIAR_REG_SWPOS: rif.rd_data = swpos_q;
         default: rif.rd_data = 32'h0;
      endcase
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence seek_hit_s;
      ce && state_q == fiar_pkg::ST_SEEK && fast_pulse;
   endsequence
   sequence hunt_wait_s;
      ce && state_q == fiar_pkg::ST_HUNT && !index_pulse && motion_q;
   endsequence

   dim_refuse_a: assert property (ce && start && !dim_ok |=> !ok_q && reject_q)
      else $error("out-of-range dimension accepted");
   motion_start_a: assert property (
      ce && accept && motion_req |=> move_en && state_q == fiar_pkg::ST_SEEK)
      else $error("reference move not started");
   no_motion_a: assert property (ce && accept && !motion_req |=> !move_en)
      else $error("motion in no-motion reference");
   done_clear_a: assert property (ce && accept && !complete |=> !ref_done)
      else $error("done not cleared by command");
   stepper_rej_a: assert property (
      ce && start && kind == fiar_pkg::KIND_STEPPER |=> !ok_q ##0 reject_q)
      else $error("stepper command accepted");
   ignore_stop_a: assert property (
      seek_hit_s ##0 opt_q[`FIAR_OPT_IGNIDX] |=> !move_en && ref_done)
      else $error("ignore-index reference did not stop");
   hunt_move_a: assert property (
      hunt_wait_s |=> move_en && state_q == fiar_pkg::ST_HUNT)
      else $error("axis stopped before index");
   latch_same_a: assert property (seek_hit_s |=> latch_q == $past(feedback_pos))
      else $error("switch position not latched");
   pos_load_a: assert property (
      ce && state_q == fiar_pkg::ST_HUNT && index_pulse |=>
      offset_q == dim_q - $past(feedback_pos) && ref_done)
      else $error("reference dimension not loaded");
endmodule

// >>> sim/fiar_fb_model.sv
// Purpose: feedback device and index source facing the block
// Assumes: one count per cycle while the block drives the axis
// Notes: the bench can preset the count and request an index
`timescale 1ns/1ps
module fiar_fb_model (
   input wire logic sys_clk,
   input wire logic move_en,
   input wire logic move_plus,
   input wire logic load,
   input wire logic [31:0] preset,
   input wire logic idx_req,
   output logic [31:0] feedback_pos,
   output logic index_in
);
   always @(posedge sys_clk) begin
      if (load) begin
         feedback_pos <= preset;
      end else if (move_en) begin
         feedback_pos <= move_plus ? feedback_pos + 1 : feedback_pos - 1;
      end
   end
   // Index every 32 counts; switch starts near mid-rev
   assign index_in = idx_req | (move_en && feedback_pos[4:0] == 5'h00);
endmodule

// >>> sim/test_fiar_top.sv
// Purpose: self-checking bench for the reference block
// Assumes: bench drives the switch pin and the queue flag
// Notes: positions checked only while the axis stands still
`timescale 1ns/1ps
`include "fiar_defs.svh"
module test_fiar_top;
   logic sys_clk = 0, rst_n = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, fast_in = 0, queue_free = 1, load = 0, idx_req = 0;
   logic [7:0] awaddr = 0, araddr = 0, axis_id, queue_number;
   logic [31:0] wdata = 0, preset = 0, rdata, move_rate, axis_position, nv_null_pos;
   logic [31:0] feedback_pos, seed = 56, rate, d, nv_val;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, resp;
   logic awready, wready, bvalid, arready, rvalid, index_in, move_en, move_plus;
   logic ref_done, nv_store, nv_seen, lsw;
   int mismatches = 0, checked = 0, cyc = 0, qn = 0;
   fiar_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .fast_in(fast_in), .index_in(index_in), .feedback_pos(feedback_pos),
      .queue_free(queue_free), .move_en(move_en), .move_plus(move_plus),
      .move_rate(move_rate), .axis_id(axis_id), .queue_number(queue_number),
      .ref_done(ref_done), .axis_position(axis_position), .nv_store(nv_store),
      .nv_null_pos(nv_null_pos));
   fiar_fb_model FB (.sys_clk(sys_clk), .move_en(move_en), .move_plus(move_plus),
      .load(load), .preset(preset), .idx_req(idx_req), .feedback_pos(feedback_pos),
      .index_in(index_in));
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (nv_store === 1'b1) begin
         nv_seen = 1;
         nv_val = nv_null_pos;
      end
      if (cyc == 30000) begin
         mismatches++;
         report_and_stop();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task report_and_stop();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      logic pa, pw, ta, tw, tb;
      pa = 1;
      pw = 1;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (pa || pw) begin
         @(negedge sys_clk);
         ta = pa & awready;
         tw = pw & wready;
         @(posedge sys_clk);
         if (ta) begin
            awvalid <= 1'b0;
            pa = 0;
         end
         if (tw) begin
            wvalid <= 1'b0;
            pw = 0;
         end
      end
      do begin
         @(negedge sys_clk);
         tb = bvalid;
         resp = bresp;
         @(posedge sys_clk);
      end while (!tb);
   endtask
   task rd(input logic [7:0] a);
      logic ta, tr;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge sys_clk);
         ta = arready;
         @(posedge sys_clk);
      end while (!ta);
      arvalid <= 1'b0;
      do begin
         @(negedge sys_clk);
         tr = rvalid;
         d = rdata;
         resp = rresp;
         @(posedge sys_clk);
      end while (!tr);
   endtask
   task cmd(input logic [31:0] cf, input logic [31:0] op, input logic [31:0] dm,
      input logic [1:0] ct);
      wr(`FIAR_REG_CFG, cf);
      wr(`FIAR_REG_OPT, op);
      wr(`FIAR_REG_DIM, dm);
      wr(`FIAR_REG_RATE, rate);
      wr(`FIAR_REG_AXIS, 32'h5A);
      wr(`FIAR_REG_CTRL, {30'h0, ct});
   endtask
   task put(input logic [31:0] p);
      preset <= p;
      load <= 1'b1;
      tick(1);
      load <= 1'b0;
   endtask
   task wait_done();
      int n;
      n = 0;
      while (ref_done !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      chk(ref_done, 1);
      tick(2);
   endtask
   task mot(input logic [31:0] op, input logic pl, input logic [31:0] p0);
      rate = rnd();
      fast_in <= 1'b0;
      put(p0);
      cmd(0, op, 0, {pl, 1'b1});
      qn++;
      chk(move_en, 1);
      chk(move_plus, pl);
      chk(move_rate, rate);
      chk(axis_id, 8'h5A);
      chk(queue_number, qn[7:0]);
      chk(resp, 2'h0);
      fast_in <= 1'b1;
      wait_done();
      chk(move_en, 0);
      chk(op[0] ? feedback_pos > 0 : feedback_pos >= 32, 1);
      lsw = !op[0];
      rd(`FIAR_REG_STAT);
      chk(d, 32'h3 | lsw << 4 | qn << 8);
      $display("motion test done");
   endtask
   task nomo(input logic [31:0] cf, input logic [31:0] op, input logic [31:0] dm);
      logic [31:0] p1, p2;
      p1 = rnd() & 32'hFFFF;
      p2 = p1 + (rnd() & 32'hFF);
      nv_seen = 0;
      fast_in <= cf[0];
      put(p1);
      cmd(cf, op, dm, 2'b01);
      chk(ref_done, 0);
      chk(move_en, 0);
      tick(2);
      fast_in <= ~cf[0];
      tick(8);
      if (!op[0]) begin
         chk(ref_done, 0);
         put(p2);
         idx_req <= 1'b1;
         tick(3);
         idx_req <= 1'b0;
      end
      wait_done();
      chk(ref_done, 1);
      chk(axis_position, dm);
      chk(queue_number, qn[7:0]);
      chk(nv_seen, op[2] & cf[4]);
      if (op[2]) chk(nv_val, p2);
      lsw = cf[3] | !op[0];
      rd(`FIAR_REG_STAT);
      chk(d, 32'h3 | lsw << 4 | qn << 8);
      rd(`FIAR_REG_SWPOS);
      if (lsw) chk(d, cf[3] ? p1 : p2 - p1);
      $display("no-motion test done");
   endtask
   initial begin
      tick(8);
      rst_n <= 1'b1;
      tick(1);
      rd(`FIAR_REG_CFG);
      chk(d, 0);
      rd(`FIAR_REG_STAT);
      chk(d, 0);
      rd(8'h24);
      chk(d, 32'h0);
      chk(resp, 2'h2);
      wr(8'h22, 32'h0);
      chk(resp, 2'h2);
      ce <= 1'b0;
      tick(2);
      chk({awready, wready, arready}, 0);
      ce <= 1'b1;
      $display("register test done");
      mot(0, 1, 3);
      mot(1, 0, 20);
      nomo(0, 2, 32'hE0000000);
      nomo(3, 0, rnd() & 32'h0FFFFFFF);
      nomo(24, 6, 32'h1FFFFFFF); // Null setup on this command only
      nomo(8, 3, rnd() & 32'h0FFFFFFF);
      for (int i = 0; i < 4; i++) begin
         queue_free <= (i != 3);
         cmd(i == 2 ? 4 : 0, 0, i == 0 ? 32'h20000000 : (i == 1 ? 32'hDFFFFFFF : 0), 1);
         rd(`FIAR_REG_STAT);
         chk(d, 32'h9 | lsw << 4 | qn << 8);
      end
      $display("refusal test done");
      report_and_stop();
   end
endmodule
